// ---- pkg/gpio_port_pkg.sv ----
`default_nettype none
package gpio_port_pkg;
    // Data-memory addresses on the core's file bus
    localparam logic [4:0] status_addr      = 5'h03;
    localparam logic [4:0] pin_data_addr    = 5'h06;
    localparam int         port_width       = 4;
    localparam int         wake_flag_bit    = 7;
    localparam int         wake_dis_bit     = 7;
    localparam int         pullup_dis_bit   = 6;
    localparam int         timer_src_bit    = 5;
    localparam int         quarter_out_bit  = 0;
    localparam logic [3:0] direction_reset  = 4'hF;
    localparam logic [7:0] option_reset     = 8'hFF;
    localparam logic [3:0] upper_read_zero  = 4'h0;
    // Pins that share pull-up and wake-up
    localparam logic [3:0] shared_pin_mask  = 4'hB;
    localparam int         sync_stages      = 3;
endpackage
`default_nettype wire

// ---- pkg/pin_bus_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface pin_bus_if;
    logic [3:0] raw;
    logic [3:0] level;
    modport src (input raw, output level);
    modport dst (input level);
endinterface
`default_nettype wire

// ---- rtl/pin_sync.sv ----
`timescale 1ns/100ps
`default_nettype none
module pin_sync (
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic ce,
    pin_bus_if.src    bus
);
    logic [3:0] s1_ff;
    logic [3:0] s2_ff;
    logic [3:0] s3_ff;
    logic [3:0] level_ff;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s1_ff    <= 4'h0;
            s2_ff    <= 4'h0;
            s3_ff    <= 4'h0;
            level_ff <= 4'h0;
        end else if (ce) begin
            s1_ff <= bus.raw;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            // Change taken only once stage two and three agree
            level_ff <= (s2_ff & s3_ff) | (level_ff & (s2_ff ^ s3_ff));
        end
    end
    assign bus.level = level_ff;
endmodule
`default_nettype wire

// ---- rtl/wake_detect.sv ----
`timescale 1ns/100ps
`default_nettype none
module wake_detect (
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       ce,
    input  wire logic       snapshot,
    input  wire logic       sleeping,
    input  wire logic [3:0] enable,
    pin_bus_if.dst          bus,
    output logic            wake
);
    logic [3:0] ref_ff;
    logic       wake_ff;
    wire  [3:0] diff = (ref_ff ^ bus.level) & enable;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ref_ff  <= 4'h0;
            wake_ff <= 1'b0;
        end else if (ce) begin
            if (snapshot) begin
                ref_ff <= bus.level;
            end
            wake_ff <= sleeping && (|diff);
        end
    end
    assign wake = wake_ff;
endmodule
`default_nettype wire

// ---- rtl/four_pin_io_port.sv ----
// Behaviour
// - Port data reads return synchronised pin levels, never the latch.
// - Only low four data bits exist; upper four read zero.
// - Pin three is input only; it is never driven.
// - Pull-up and wake-up apply to pins zero, one, three together.
// - Reset-input mode kills pin three wake-up; pull-up from config word.
// - Direction loads from working register only on direction-load instruction.
// - Direction 1 floats pin; 0 drives latch value.
// - Every reset sets all direction bits to one.
// - Output latch holds until rewritten; inputs are not latched.
// - Analog, clock output, timer input, reset outrank direction control.
// - Digital mode only when all overriding selects of a pin are zero.
// - Bit set and clear read pins, modify one bit, write all latches.
// - Writes land at cycle end; reads sample at cycle start.
// - Wake flag set on wake-up reset, cleared on other resets.
// - Shared wake-up and pull-up enables are active low.
// - Output-mode pins lose wake-up and pull-up.
// - Trim bit zero drives clock quarter onto pin two.
`timescale 1ns/100ps
`default_nettype none
module four_pin_io_port (
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       ce,
    input  wire logic [4:0] file_addr,
    input  wire logic       file_rd,
    input  wire logic       file_wr,
    input  wire logic [7:0] file_wdata,
    input  wire logic       bit_set_instr,
    input  wire logic       bit_clear_instr,
    input  wire logic [2:0] bit_sel,
    input  wire logic       direction_load,
    input  wire logic       option_load,
    input  wire logic [7:0] work_reg,
    input  wire logic       wake_reset_cause,
    input  wire logic       sleeping,
    input  wire logic       external_reset_select,
    input  wire logic       config_pullup_enable,
    input  wire logic       analog_select_zero,
    input  wire logic       analog_select_one,
    input  wire logic       oscillator_trim_bit0,
    input  wire logic       clock_quarter,
    input  wire logic [3:0] pin_in,
    output logic [7:0]      file_rdata,
    output logic [3:0]      pin_out,
    output logic [3:0]      pin_oe,
    output logic [3:0]      pullup_en,
    output logic            timer_clock_input,
    output logic            external_reset_input,
    output logic            analog_channel_zero,
    output logic            analog_channel_one,
    output logic            wake_event
);
    // ==========================================
    // Pin capture and wake-up
    // ==========================================
    pin_bus_if pins ();
    assign pins.raw = pin_in;

    pin_sync u_sync (
        .clk    (clk),
        .arst_n (arst_n),
        .ce     (ce),
        .bus    (pins)
    );

    logic [3:0] latch_ff;
    logic [3:0] dir_ff;
    logic [7:0] option_ff;
    logic       wake_flag_ff;
    logic [7:0] rdata_ff;
    logic [3:0] out_ff;
    logic [3:0] oe_ff;
    logic [3:0] pu_ff;
    logic       tck_ff;
    logic       mrst_ff;
    logic       an0_ff;
    logic       an1_ff;
    logic       wake_flag_seen_ff;

    // ==========================================
    // Decode
    // ==========================================
    wire        hit_data   = file_addr == gpio_port_pkg::pin_data_addr;
    wire        hit_status = file_addr == gpio_port_pkg::status_addr;
    wire        rmw        = hit_data && (bit_set_instr || bit_clear_instr);
    wire        timer_src  = option_ff[gpio_port_pkg::timer_src_bit];
    wire        quarter_en = oscillator_trim_bit0;
    wire        wake_en    = !option_ff[gpio_port_pkg::wake_dis_bit];
    wire        pull_en    = !option_ff[gpio_port_pkg::pullup_dis_bit];
    wire [3:0]  level      = pins.level;
    wire [3:0]  one_hot    = 4'h1 << bit_sel[1:0];
    wire        in_range   = bit_sel < 3'h4;
    // RMW: whole port from pins, only the addressed bit altered
    wire [3:0]  rmw_val    = !in_range ? level :
                             bit_set_instr ? (level | one_hot) : (level & ~one_hot);
    wire        wr_data    = hit_data && file_wr && !rmw;

    // Digital availability per pin
    wire        dig0 = !analog_select_zero;
    wire        dig1 = !analog_select_one;
    wire        dig2 = !quarter_en && !timer_src;
    wire        dig3 = !external_reset_select;

    // Pin two: clock quarter wins, then timer input, then direction
    wire        p2_drive = quarter_en || (!timer_src && !dir_ff[2]);
    wire        p2_val   = quarter_en ? clock_quarter : latch_ff[2];

    wire [3:0]  nxt_oe  = {1'b0, p2_drive,
                           dig1 && !dir_ff[1], dig0 && !dir_ff[0]};
    wire [3:0]  nxt_out = {1'b0, p2_val, latch_ff[1:0]};

    // Output-mode pins lose pull-up and wake-up; shared enable only
    wire [3:0]  shared_in = gpio_port_pkg::shared_pin_mask & dir_ff;
    wire [3:0]  nxt_pu    = {dig3 ? (pull_en && dir_ff[3]) : config_pullup_enable,
                             1'b0,
                             pull_en & shared_in[1], pull_en & shared_in[0]};
    wire [3:0]  wake_mask = (wake_en ? shared_in : 4'h0) & {dig3, 3'h7};

    wire [7:0]  status_val = {wake_flag_ff, 7'h00};
    wire [7:0]  data_val   = {gpio_port_pkg::upper_read_zero, level};
    wire [7:0]  nxt_rdata  = hit_data ? data_val : hit_status ? status_val : 8'h00;

    logic wake_event_w;

    wake_detect u_wake (
        .clk      (clk),
        .arst_n   (arst_n),
        .ce       (ce),
        .snapshot (file_rd && hit_data),
        .sleeping (sleeping),
        .enable   (wake_mask),
        .bus      (pins),
        .wake     (wake_event_w)
    );

    // ==========================================
    // Registers
    // ==========================================
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            latch_ff  <= 4'h0;
            dir_ff    <= gpio_port_pkg::direction_reset;
            option_ff <= gpio_port_pkg::option_reset;
        end else if (ce) begin
            // Latch updates at the cycle end; held otherwise
            if (rmw && file_wr) begin
                latch_ff <= rmw_val;
            end else if (wr_data) begin
                latch_ff <= file_wdata[3:0];
            end
            if (direction_load) begin
                dir_ff <= work_reg[3:0];
            end
            if (option_load) begin
                option_ff <= work_reg;
            end
        end
    end

    // Reset cause is caught after release, not during the reset itself
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wake_flag_seen_ff <= 1'b0;
            wake_flag_ff      <= 1'b0;
        end else if (ce) begin
            if (!wake_flag_seen_ff) begin
                wake_flag_seen_ff <= 1'b1;
                wake_flag_ff      <= wake_reset_cause;
            end else if (hit_status && file_wr) begin
                wake_flag_ff <= file_wdata[gpio_port_pkg::wake_flag_bit];
            end
        end
    end

    // Registered outputs; read data sampled from pins, not held
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_ff <= 8'h00;
            out_ff   <= 4'h0;
            oe_ff    <= 4'h0;
            pu_ff    <= 4'h0;
            tck_ff   <= 1'b0;
            mrst_ff  <= 1'b0;
            an0_ff   <= 1'b0;
            an1_ff   <= 1'b0;
        end else if (ce) begin
            rdata_ff <= nxt_rdata;
            out_ff   <= nxt_out;
            oe_ff    <= nxt_oe;
            pu_ff    <= nxt_pu;
            tck_ff   <= !quarter_en && timer_src && level[2];
            mrst_ff  <= external_reset_select && !level[3];
            an0_ff   <= analog_select_zero;
            an1_ff   <= analog_select_one;
        end
    end

    assign file_rdata           = rdata_ff;
    assign pin_out              = out_ff;
    assign pin_oe               = oe_ff;
    assign pullup_en            = pu_ff;
    assign timer_clock_input    = tck_ff;
    assign external_reset_input = mrst_ff;
    assign analog_channel_zero  = an0_ff;
    assign analog_channel_one   = an1_ff;
    assign wake_event           = wake_event_w;
endmodule
`default_nettype wire

// ---- tb/pin_world.sv ----
`timescale 1ns/100ps
`default_nettype none
// ==========
// External pin circuitry
module pin_world (
    input  wire logic       clk,
    input  wire logic [3:0] pin_out,
    input  wire logic [3:0] pin_oe,
    input  wire logic [3:0] pullup_en,
    input  wire logic [3:0] ext_en,
    input  wire logic [3:0] ext_val,
    output logic      [3:0] pin_in
);
    logic [3:0] drift_ff = 4'h5;
    // Unheld lines wander so a stale level never reads as valid
    always @(posedge clk) drift_ff <= ~drift_ff;
    // An outside source overpowers the driver, as a clamp would
    always_comb
        for (int i = 0; i < 4; i++)
            pin_in[i] = ext_en[i] ? ext_val[i] : pin_oe[i] ? pin_out[i] :
                        pullup_en[i] ? 1'b1 : drift_ff[i];
endmodule
`default_nettype wire

// ---- tb/four_pin_io_port_assertions.sv ----
`timescale 1ns/100ps
`default_nettype none
module port_checks (
    input wire logic       clk, arst_n, ce, file_rd, file_wr, bit_set_instr, bit_clear_instr,
    input wire logic       direction_load, sleeping, analog_select_zero, analog_select_one,
    input wire logic       oscillator_trim_bit0, analog_channel_zero, wake_event,
    input wire logic [4:0] file_addr,
    input wire logic [7:0] file_wdata, work_reg, file_rdata,
    input wire logic [3:0] pin_in, pin_out, pin_oe, pullup_en
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    logic [3:0] last_ff, calm_ff, nxt_calm;
    logic       rd6, wr6;
    assign rd6 = ce && file_rd && file_addr == 5'h06;
    assign wr6 = ce && file_wr && file_addr == 5'h06;
    // Cycles the pins have been still, saturating
    assign nxt_calm = (pin_in != last_ff) ? 4'h0 : (calm_ff == 4'hF) ? calm_ff : calm_ff + 4'h1;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            last_ff <= 4'h0;
            calm_ff <= 4'h0;
        end else begin
            last_ff <= pin_in;
            calm_ff <= nxt_calm;
        end
    end
    // ==========
    // Checks
    AST_UPPER_ZERO: assert property (rd6 |=> file_rdata[7:4] == 4'h0)
        else $error("upper data bits not zero");
    AST_PIN_READ: assert property (rd6 && calm_ff > 4'h6 |=> file_rdata[3:0] == $past(pin_in))
        else $error("port read differs from pins");
    AST_PIN3_INPUT: assert property (pin_oe[3] == 1'b0)
        else $error("pin three driven");
    AST_PIN2_NO_PULL: assert property (pullup_en[2] == 1'b0)
        else $error("pin two pulled up");
    AST_DIR_RESET: assert property ($rose(arst_n) |-> (pin_oe == 4'h0) [*2])
        else $error("driver on after reset");
    AST_DIR_DRIVE: assert property (direction_load && !work_reg[1] && !analog_select_one ##1
        !direction_load && !analog_select_one |=> pin_oe[1]) else $error("pin one not driven");
    AST_ANALOG_FLOAT: assert property (analog_select_zero [*2] |-> !pin_oe[0] && analog_channel_zero)
        else $error("analog pin zero still digital");
    AST_QUARTER_OUT: assert property (oscillator_trim_bit0 [*3] |-> pin_oe[2])
        else $error("clock quarter not on pin two");
    AST_AWAKE_QUIET: assert property (!sleeping [*2] |-> !wake_event)
        else $error("wake event while awake");
    AST_WRITE_OUT: assert property (wr6 && !bit_set_instr && !bit_clear_instr |->
        ##2 pin_out[1] == $past(file_wdata[1], 2)) else $error("latch not on pin");
endmodule
`default_nettype wire

// ---- tb/four_pin_io_port_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module four_pin_io_port_tb_top;
    logic       clk = '0, arst_n = '0, ce = '1, file_rd = '0, file_wr = '0, bit_set_instr = '0;
    logic       bit_clear_instr = '0, direction_load = '0, option_load = '0, sleeping = '0;
    logic       wake_reset_cause = '0, external_reset_select = '0, config_pullup_enable = '0;
    logic       analog_select_zero = '0, analog_select_one = '0, oscillator_trim_bit0 = '0;
    logic       clock_quarter = '0, timer_clock_input, external_reset_input;
    logic       analog_channel_zero, analog_channel_one, wake_event;
    logic [2:0] bit_sel = '0;
    logic [4:0] file_addr = '0;
    logic [7:0] file_wdata = '0, work_reg = '0, file_rdata, rd_val;
    logic [3:0] pin_in, pin_out, pin_oe, pullup_en, ext_en = 4'hF, ext_val = 4'h0;
    int         fail_count = 0, checks = 0, cycles = 0;
    four_pin_io_port u_four_pin_io_port (.*);
    pin_world u_pin_world (.*);
    always #25 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            fail_count++;
            finish_test();
        end
    end
    // ==========
    // Access tasks
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic load(input logic opt, input logic [7:0] v);
        work_reg = v;
        direction_load = !opt;
        option_load = opt;
        cyc(1);
        direction_load = 1'b0;
        option_load = 1'b0;
        cyc(2);
    endtask
    task automatic wr(input logic [7:0] d, input logic [1:0] rmw, input logic [2:0] b);
        file_addr = 5'h06;
        file_wdata = d;
        {bit_set_instr, bit_clear_instr} = rmw;
        bit_sel = b;
        file_wr = 1'b1;
        cyc(1);
        file_wr = 1'b0;
        {bit_set_instr, bit_clear_instr} = 2'h0;
        cyc(2);
    endtask
    task automatic rd(input logic [4:0] a);
        file_addr = a;
        file_rd = 1'b1;
        cyc(1);
        file_rd = 1'b0;
        rd_val = file_rdata;
    endtask
    task automatic finish_test;
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // ==========
    // Tests
    initial begin
        cyc(5);
        arst_n = 1'b1;
        cyc(2);
        check({4'h0, pin_oe}, 8'h00);
        rd(5'h03);
        check(rd_val & 8'h80, 8'h00);
        $display("test reset done");
        // Reset leaves pin two on the timer input; give it back to direction control
        load(1'b1, 8'hDF);
        load(1'b0, 8'h08);
        check({4'h0, pin_oe}, 8'h07);
        ext_en = 4'hA;
        wr(8'h07, 2'h0, 3'h0);
        cyc(5);
        rd(5'h06);
        check(rd_val, 8'h05);
        check({4'h0, pin_out}, 8'h07);
        $display("test pin read done");
        ext_en = 4'hF;
        ext_val = 4'h2;
        cyc(5);
        wr(8'hFF, 2'h1, 3'h2);
        check({4'h0, pin_out}, 8'h02);
        wr(8'h00, 2'h2, 3'h0);
        check({4'h0, pin_out}, 8'h03);
        ext_en = 4'h8;
        cyc(5);
        rd(5'h06);
        check(rd_val, 8'h03);
        $display("test bit ops done");
        load(1'b0, 8'h0C);
        analog_select_zero = 1'b1;
        oscillator_trim_bit0 = 1'b1;
        cyc(3);
        check({pin_oe, 3'h0, analog_channel_zero}, 8'h61);
        analog_select_zero = 1'b0;
        oscillator_trim_bit0 = 1'b0;
        load(1'b0, 8'h0F);
        check({4'h0, pin_oe}, 8'h00);
        $display("test precedence done");
        load(1'b1, 8'h1F);
        check({4'h0, pullup_en}, 8'h0B);
        load(1'b0, 8'h0E);
        check({4'h0, pullup_en}, 8'h0A);
        load(1'b1, 8'hDF);
        check({4'h0, pullup_en}, 8'h00);
        $display("test pull-ups done");
        load(1'b1, 8'hFF);
        load(1'b0, 8'h0B);
        ext_en = 4'hF;
        ext_val = 4'h4;
        external_reset_select = 1'b1;
        config_pullup_enable = 1'b1;
        analog_select_one = 1'b1;
        cyc(6);
        check({4'h0, pullup_en}, 8'h08);
        check({4'h0, pin_oe}, 8'h00);
        check({5'h0, timer_clock_input, external_reset_input, analog_channel_one}, 8'h07);
        external_reset_select = 1'b0;
        config_pullup_enable = 1'b0;
        analog_select_one = 1'b0;
        $display("test pin modes done");
        load(1'b1, 8'h1F);
        load(1'b0, 8'h0F);
        ext_en = 4'hF;
        ext_val = 4'h0;
        cyc(5);
        rd(5'h06);
        sleeping = 1'b1;
        ext_val = 4'h4;
        cyc(8);
        check({7'h0, wake_event}, 8'h00);
        ext_val = 4'h5;
        cyc(8);
        check({7'h0, wake_event}, 8'h01);
        sleeping = 1'b0;
        cyc(2);
        check({7'h0, wake_event}, 8'h00);
        $display("test wake done");
        wake_reset_cause = 1'b1;
        arst_n = 1'b0;
        cyc(2);
        arst_n = 1'b1;
        cyc(2);
        wake_reset_cause = 1'b0;
        rd(5'h03);
        check(rd_val & 8'h80, 8'h80);
        check({4'h0, pin_oe}, 8'h00);
        $display("test wake reset done");
        finish_test();
    end
endmodule
bind four_pin_io_port port_checks u_port_checks (.*);
`default_nettype wire
